// ---- rtl/fsw_defines.svh ----
/*
  Constants of the flash status and write latch block: status bit
  positions, reset values and instruction codes.
  Assumes inclusion by bare name from files under rtl/.
*/
`ifndef FSW_DEFINES_SVH
`define FSW_DEFINES_SVH

// ==========================================================
// Status byte layout
`define FSW_BIT_BUSY 0
`define FSW_BIT_WLATCH 1
`define FSW_BP_LSB 2
`define FSW_BP_MSB 5
`define FSW_BIT_QUAD 6
`define FSW_BIT_LOCK 7
`define FSW_STATUS_RST 8'h00
`define FSW_BP_NONE 4'h0

// ==========================================================
// Serial framing
`define FSW_BYTE_LAST 3'h7
`define FSW_CNT_RST 3'h0
`define FSW_BYTE_RST 8'h00
`define FSW_SYNC_RST 4'h5

// ==========================================================
// Instruction codes
`define FSW_OPC_SET_LATCH 8'h06
`define FSW_OPC_CLR_LATCH 8'h04
`define FSW_OPC_STATUS_WR 8'h01
`define FSW_OPC_STATUS_RD 8'h05
`define FSW_OPC_EXT_RD 8'h81
`define FSW_OPC_RESET 8'h99
`define FSW_OPC_SUSPEND 8'h75
`define FSW_OPC_CHIP_ERASE_A 8'hc7
`define FSW_OPC_CHIP_ERASE_B 8'h60
`define FSW_OPC_ALT_RDPARAM 8'hc0
`define FSW_OPC_ALT_BANK 8'h17

`endif

// ---- rtl/fsw_pkg.sv ----
/*
  Types of the flash status and write latch block.
  Assumes nothing beyond the defines header.
*/
package fsw_pkg;

  // ==========================================================
  // Frame states, one-hot
  typedef enum logic [5:0] {
    FSW_S_IDLE    = 6'h01,
    FSW_S_OPCODE  = 6'h02,
    FSW_S_WRDATA  = 6'h04,
    FSW_S_READOUT = 6'h08,
    FSW_S_HOLDOFF = 6'h10,
    FSW_S_SKIP    = 6'h20
  } fsw_state_e;

endpackage : fsw_pkg

// ---- rtl/fsw_sync.sv ----
/*
  Two-stage synchroniser for the four serial pins.
  Assumes pins asynchronous to clk; reset is synchronous, active low.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fsw_defines.svh"

module fsw_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Pins in, synchronised out
  input wire logic [3:0] din,
  output logic [3:0] dout
);

  localparam logic [3:0] SYNC_RST = `FSW_SYNC_RST;

  logic [3:0] meta_reg;
  logic [3:0] sync_reg;

  // ==========================================================
  // Two flops per pin
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_bit
      always_ff @(posedge clk) begin
        if (!rstn) begin
          meta_reg[gi] <= SYNC_RST[gi];
          sync_reg[gi] <= SYNC_RST[gi];
        end else begin
          meta_reg[gi] <= din[gi];
          sync_reg[gi] <= meta_reg[gi];
        end
      end
    end
  endgenerate

  assign dout = sync_reg;

endmodule : fsw_sync
`default_nettype wire

// ---- rtl/fsw_opcode_class.sv ----
/*
  Classifies an instruction code: latch-required, program or erase,
  and handed to the array engine.
  Assumes a stable code from the same clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fsw_defines.svh"

module fsw_opcode_class (
  // Code in
  input wire logic [7:0] opcode,
  // Classes out
  output logic needs_latch,
  output logic prog_erase,
  output logic engine_op
);

  // ==========================================================
  // Decode
  always_comb begin
    needs_latch = 1'b0;
    prog_erase = 1'b0;
    case (opcode)
      8'h02, 8'h12, 8'h32, 8'h38, 8'h34, 8'h3e: begin
        needs_latch = 1'b1;
        prog_erase = 1'b1;
      end
      8'hd7, 8'h20, 8'h21, 8'h52, 8'h5c, 8'hd8, 8'hdc, 8'hc7, 8'h60: begin
        needs_latch = 1'b1;
        prog_erase = 1'b1;
      end
      8'h01, 8'h42, 8'h65, 8'h63, 8'h85, 8'h83: begin
        needs_latch = 1'b1;
      end
      8'h64, 8'h62, 8'h15, 8'h18, 8'hc5: begin
        needs_latch = 1'b1;
      end
      8'hfb, 8'he1, 8'hfd, 8'he3, 8'he4, 8'h2f, 8'ha6, 8'h91, 8'h7e, 8'h98, 8'he8: begin
        needs_latch = 1'b1;
      end
      8'h43, 8'h4a: begin
        needs_latch = 1'b1;
      end
      default: begin
        needs_latch = 1'b0;
        prog_erase = 1'b0;
      end
    endcase
  end

  // Alternate volatile writes go to the engine without the latch
  assign engine_op = needs_latch | (opcode == `FSW_OPC_ALT_RDPARAM) |
                     (opcode == `FSW_OPC_ALT_BANK);

endmodule : fsw_opcode_class
`default_nettype wire

// ---- rtl/fsw_status_latch.sv ----
/*
  Status byte and write-enable latch of a serial flash, with the
  instruction gate and a single-lane mode-0 serial front end.
  Assumes sck, cs_n, si, wp_n arrive from pins; op_done comes from the
  array engine on clk as a one-cycle pulse.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fsw_defines.svh"

module fsw_status_latch
  import fsw_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Serial pins
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic wp_n,
  output logic so_out,
  output logic so_oe_n,
  // Engine handshake
  output logic op_start,
  output logic [7:0] op_code,
  output logic op_suspend,
  output logic sw_reset_req,
  input wire logic op_done,
  // Status view
  output logic [7:0] status_byte,
  output logic [3:0] block_guard,
  output logic lane2_data_mode,
  output logic lane3_data_mode
);

  // ==========================================================
  // Pin synchronisation and edges
  logic [3:0] sync_bus;
  logic s_sck, s_cs_n, s_si, s_wp_n;
  logic sck_prev_reg, cs_prev_reg;
  logic cs_active, cs_rise, sck_rise, sck_fall;

  fsw_sync u_sync (
    .clk(clk),
    .rstn(rstn),
    .din({sck, cs_n, si, wp_n}),
    .dout(sync_bus)
  );

  assign {s_sck, s_cs_n, s_si, s_wp_n} = sync_bus;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      sck_prev_reg <= 1'b0;
      cs_prev_reg <= 1'b1;
    end else begin
      sck_prev_reg <= s_sck;
      cs_prev_reg <= s_cs_n;
    end
  end

  assign cs_active = ~s_cs_n;
  assign cs_rise = s_cs_n & ~cs_prev_reg;
  assign sck_rise = cs_active & s_sck & ~sck_prev_reg;
  assign sck_fall = cs_active & ~s_sck & sck_prev_reg;

  // ==========================================================
  // Bit counter and receive shifter
  logic [2:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] rx_byte;
  logic byte_done;

  assign rx_byte = {shift_reg[6:0], s_si};
  assign byte_done = sck_rise & (bit_cnt_reg == `FSW_BYTE_LAST);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      bit_cnt_reg <= `FSW_CNT_RST;
      shift_reg <= `FSW_BYTE_RST;
    end else if (!cs_active) begin
      bit_cnt_reg <= `FSW_CNT_RST;
      shift_reg <= `FSW_BYTE_RST;
    end else if (sck_rise) begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      shift_reg <= rx_byte;
    end
  end

  // ==========================================================
  // Status bits
  logic busy_flag_reg, write_latch_flag_reg;
  logic [3:0] block_guard_reg;
  logic quad_lane_enable_reg, status_write_lock_reg;
  logic busy_pe_reg, op_clr_reg;
  logic [7:0] status_live;
  logic lock_active;

  assign status_live = {status_write_lock_reg, quad_lane_enable_reg, block_guard_reg,
                        write_latch_flag_reg, busy_flag_reg};
  assign lock_active = status_write_lock_reg & ~s_wp_n;

  // ==========================================================
  // Instruction gate
  fsw_state_e state_reg, disp_state;
  logic cls_latch, cls_pe, cls_eng;
  logic busy_ok, cmd_now, start_now;
  logic [7:0] pend_code_reg, wr_data_reg;
  logic pend_pe_reg, pend_clr_reg;

  fsw_opcode_class u_cls (
    .opcode(rx_byte),
    .needs_latch(cls_latch),
    .prog_erase(cls_pe),
    .engine_op(cls_eng)
  );

  always_comb begin
    busy_ok = (rx_byte == `FSW_OPC_STATUS_RD) | (rx_byte == `FSW_OPC_EXT_RD) |
              (rx_byte == `FSW_OPC_RESET);
    busy_ok = busy_ok | ((rx_byte == `FSW_OPC_SUSPEND) & busy_pe_reg);
    disp_state = FSW_S_SKIP;
    if (busy_flag_reg && !busy_ok) begin
      disp_state = FSW_S_SKIP;
    end else if (cls_latch && !write_latch_flag_reg) begin
      disp_state = FSW_S_SKIP;
    end else if (rx_byte == `FSW_OPC_STATUS_WR) begin
      disp_state = lock_active ? FSW_S_SKIP : FSW_S_WRDATA;
    end else if (rx_byte == `FSW_OPC_STATUS_RD) begin
      disp_state = FSW_S_READOUT;
    end else if (((rx_byte == `FSW_OPC_CHIP_ERASE_A) || (rx_byte == `FSW_OPC_CHIP_ERASE_B)) &&
                 (block_guard_reg != `FSW_BP_NONE)) begin
      disp_state = FSW_S_SKIP;
    end else if (cls_eng) begin
      disp_state = FSW_S_HOLDOFF;
    end
  end

  assign cmd_now = byte_done & (state_reg == FSW_S_OPCODE) & (~busy_flag_reg | busy_ok);
  assign start_now = cs_rise & (state_reg == FSW_S_HOLDOFF);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_reg <= FSW_S_IDLE;
    end else if (!cs_active) begin
      state_reg <= FSW_S_IDLE;
    end else begin
      case (state_reg)
        FSW_S_IDLE: begin
          state_reg <= FSW_S_OPCODE;
        end
        FSW_S_OPCODE: begin
          if (byte_done) begin
            state_reg <= disp_state;
          end
        end
        FSW_S_WRDATA: begin
          if (byte_done) begin
            state_reg <= FSW_S_HOLDOFF;
          end
        end
        FSW_S_READOUT, FSW_S_HOLDOFF, FSW_S_SKIP: begin
          state_reg <= state_reg;
        end
        default: begin
          state_reg <= FSW_S_IDLE;
        end
      endcase
    end
  end

  // Pending instruction and status data byte
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pend_code_reg <= `FSW_BYTE_RST;
      pend_pe_reg <= 1'b0;
      pend_clr_reg <= 1'b0;
      wr_data_reg <= `FSW_BYTE_RST;
    end else if (byte_done && (state_reg == FSW_S_OPCODE)) begin
      pend_code_reg <= rx_byte;
      pend_pe_reg <= cls_pe;
      pend_clr_reg <= cls_latch;
    end else if (byte_done && (state_reg == FSW_S_WRDATA)) begin
      wr_data_reg <= rx_byte;
    end
  end

  // ==========================================================
  // Write latch
  always_ff @(posedge clk) begin
    if (!rstn) begin
      write_latch_flag_reg <= 1'b0;
    end else if (cmd_now && (rx_byte == `FSW_OPC_SET_LATCH)) begin
      write_latch_flag_reg <= 1'b1;
    end else if (cmd_now && (rx_byte == `FSW_OPC_CLR_LATCH)) begin
      write_latch_flag_reg <= 1'b0;
    end else if (op_done && busy_flag_reg && op_clr_reg) begin
      write_latch_flag_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Busy and engine requests
  always_ff @(posedge clk) begin
    if (!rstn) begin
      busy_flag_reg <= 1'b0;
      busy_pe_reg <= 1'b0;
      op_clr_reg <= 1'b0;
    end else if (start_now) begin
      busy_flag_reg <= 1'b1;
      busy_pe_reg <= pend_pe_reg;
      op_clr_reg <= pend_clr_reg;
    end else if (op_done) begin
      busy_flag_reg <= 1'b0;
      busy_pe_reg <= 1'b0;
    end
  end

  logic op_start_reg, op_suspend_reg, sw_reset_reg;
  logic [7:0] op_code_reg;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      op_start_reg <= 1'b0;
      op_code_reg <= `FSW_BYTE_RST;
      op_suspend_reg <= 1'b0;
      sw_reset_reg <= 1'b0;
    end else begin
      op_start_reg <= start_now;
      op_code_reg <= start_now ? pend_code_reg : op_code_reg;
      op_suspend_reg <= cmd_now & busy_flag_reg & busy_pe_reg &
                        (rx_byte == `FSW_OPC_SUSPEND);
      sw_reset_reg <= cmd_now & (rx_byte == `FSW_OPC_RESET);
    end
  end

  // ==========================================================
  // Protection, quad and lock bits
  always_ff @(posedge clk) begin
    if (!rstn) begin
      block_guard_reg <= `FSW_BP_NONE;
      quad_lane_enable_reg <= 1'b0;
      status_write_lock_reg <= 1'b0;
    end else if (start_now && (pend_code_reg == `FSW_OPC_STATUS_WR) && !lock_active) begin
      block_guard_reg <= wr_data_reg[`FSW_BP_MSB:`FSW_BP_LSB];
      quad_lane_enable_reg <= wr_data_reg[`FSW_BIT_QUAD];
      status_write_lock_reg <= wr_data_reg[`FSW_BIT_LOCK];
    end
  end

  // ==========================================================
  // Status readout
  logic [7:0] snap_reg;
  logic so_out_reg, so_oe_n_reg;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      snap_reg <= `FSW_STATUS_RST;
    end else if (byte_done) begin
      snap_reg <= status_live;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      so_out_reg <= 1'b0;
      so_oe_n_reg <= 1'b1;
    end else if (!cs_active) begin
      so_out_reg <= 1'b0;
      so_oe_n_reg <= 1'b1;
    end else if (sck_fall && (state_reg == FSW_S_READOUT)) begin
      so_out_reg <= snap_reg[`FSW_BYTE_LAST - bit_cnt_reg];
      so_oe_n_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Outputs
  assign so_out = so_out_reg;
  assign so_oe_n = so_oe_n_reg;
  assign op_start = op_start_reg;
  assign op_code = op_code_reg;
  assign op_suspend = op_suspend_reg;
  assign sw_reset_req = sw_reset_reg;
  assign status_byte = status_live;
  assign block_guard = block_guard_reg;
  assign lane2_data_mode = quad_lane_enable_reg;
  assign lane3_data_mode = quad_lane_enable_reg;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  logic st_op;
  assign st_op = byte_done & (state_reg == FSW_S_OPCODE);

  property p_read_bit;
    sck_fall && (state_reg == FSW_S_READOUT) |=>
      so_out_reg == $past(snap_reg[`FSW_BYTE_LAST - bit_cnt_reg]) && !so_oe_n_reg;
  endproperty
  a_read_bit: assert property (p_read_bit) else $error("readout bit wrong");

  property p_start_busy;
    start_now |=> busy_flag_reg && op_start_reg ##1 !op_start_reg;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("busy not set at start");

  property p_wr_keeps_latch;
    start_now && (pend_code_reg == `FSW_OPC_STATUS_WR) |=>
      write_latch_flag_reg == $past(write_latch_flag_reg);
  endproperty
  a_wr_keeps_latch: assert property (p_wr_keeps_latch) else $error("latch moved");

  property p_wr_bits;
    start_now && (pend_code_reg == `FSW_OPC_STATUS_WR) && !lock_active |=>
      status_live[7:2] == $past(wr_data_reg[7:2]);
  endproperty
  a_wr_bits: assert property (p_wr_bits) else $error("status bits not written");

  property p_busy_refuse;
    st_op && busy_flag_reg && (rx_byte == `FSW_OPC_SET_LATCH) |=>
      (state_reg == FSW_S_SKIP) && !write_latch_flag_reg;
  endproperty
  a_busy_refuse: assert property (p_busy_refuse) else $error("taken while busy");

  property p_done_ready;
    op_done && !start_now |=> !busy_flag_reg && (status_byte[`FSW_BIT_BUSY] == 1'b0);
  endproperty
  a_done_ready: assert property (p_done_ready) else $error("busy stuck");

  property p_no_latch;
    st_op && cls_latch && !write_latch_flag_reg |=> state_reg == FSW_S_SKIP;
  endproperty
  a_no_latch: assert property (p_no_latch) else $error("write without latch");

  property p_set_latch;
    st_op && !busy_flag_reg && (rx_byte == `FSW_OPC_SET_LATCH) |=>
      write_latch_flag_reg ##1 status_byte[`FSW_BIT_WLATCH];
  endproperty
  a_set_latch: assert property (p_set_latch) else $error("latch not set");

  property p_clr_latch;
    st_op && !busy_flag_reg && (rx_byte == `FSW_OPC_CLR_LATCH) |=> !write_latch_flag_reg;
  endproperty
  a_clr_latch: assert property (p_clr_latch) else $error("latch not cleared");

  property p_auto_clr;
    op_done && busy_flag_reg && op_clr_reg |=> !write_latch_flag_reg;
  endproperty
  a_auto_clr: assert property (p_auto_clr) else $error("latch kept after op");

  property p_lock;
    st_op && lock_active && (rx_byte == `FSW_OPC_STATUS_WR) |=> state_reg == FSW_S_SKIP;
  endproperty
  a_lock: assert property (p_lock) else $error("locked status written");

  property p_suspend;
    st_op && busy_flag_reg && busy_pe_reg && (rx_byte == `FSW_OPC_SUSPEND) |=> op_suspend_reg;
  endproperty
  a_suspend: assert property (p_suspend) else $error("suspend lost");

  c_readout: cover property (state_reg == FSW_S_READOUT ##[1:300] byte_done);
  c_status_wr: cover property (start_now && (pend_code_reg == `FSW_OPC_STATUS_WR));
  c_busy_done: cover property (busy_flag_reg ##[1:1000] op_done);

endmodule : fsw_status_latch
`default_nettype wire

// ---- tb/fsw_host_model.sv ----
/*
  Host serial controller model: mode-0 frames, MSB first, link clock
  of 400 ns made from clk (4 clk per half period).
  Assumes a 20 MHz clk; tasks are called from the bench.
*/
`timescale 1ns/1ps
`default_nettype none

module fsw_host_model (
  // Clock
  input wire logic clk,
  // Serial pins
  output logic sck,
  output logic cs_n,
  output logic si,
  input wire logic so_out,
  input wire logic so_oe_n,
  // Read result
  output logic [7:0] rd_byte,
  output logic oe_seen
);
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    rd_byte = 8'h00;
    oe_seen = 1'b0;
  end

  // ==========================================================
  // Frame: n bytes from d, first byte in d[23:16]
  task automatic frame(input logic [23:0] d, input int n);
    logic [23:0] sh;
    sh = d;
    @(posedge clk);
    oe_seen <= 1'b0;
    cs_n <= 1'b0;
    si <= sh[23];
    for (int i = 0; i < n * 8; i++) begin
      repeat (4) @(posedge clk);
      sck <= 1'b1;
      repeat (4) @(posedge clk);
      rd_byte <= {rd_byte[6:0], so_out};
      if (so_oe_n === 1'b0) begin
        oe_seen <= 1'b1;
      end
      sck <= 1'b0;
      sh = sh << 1;
      si <= sh[23];
    end
    repeat (4) @(posedge clk);
    cs_n <= 1'b1;
    si <= ~si;
    repeat (4) @(posedge clk);
  endtask : frame
endmodule : fsw_host_model
`default_nettype wire

// ---- tb/tb.sv ----
/*
  Self-checking bench of the status and write latch block.
  Assumes the host model drives the serial pins; the bench plays the engine.
*/
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic clk;
  logic rstn;
  logic wp_n;
  logic op_done;
  logic sck;
  logic cs_n;
  logic si;
  logic so_out;
  logic so_oe_n;
  logic op_start;
  logic [7:0] op_code;
  logic op_suspend;
  logic sw_reset_req;
  logic [7:0] status_byte;
  logic [3:0] block_guard;
  logic lane2_data_mode;
  logic lane3_data_mode;
  logic [7:0] rd_byte;
  logic oe_seen;
  int error_cnt = 0;
  int checked = 0;
  int starts = 0;
  int susp = 0;
  int resets = 0;
  int n0;
  // Rows: {needs latch, code}
  localparam logic [8:0] ROWS [41] = '{9'h102, 9'h112, 9'h132, 9'h138, 9'h134,
    9'h13e, 9'h1d7, 9'h120, 9'h121, 9'h152, 9'h15c, 9'h1d8, 9'h1dc, 9'h1c7, 9'h160,
    9'h101, 9'h142, 9'h165, 9'h163, 9'h185, 9'h183, 9'h164, 9'h162, 9'h115, 9'h118,
    9'h1c5, 9'h1fb, 9'h1e1, 9'h1fd, 9'h1e3, 9'h1e4, 9'h12f, 9'h1a6, 9'h191, 9'h17e,
    9'h198, 9'h1e8, 9'h143, 9'h14a, 9'h0c0, 9'h017};

  fsw_status_latch u_fsw_status_latch (.clk(clk), .rstn(rstn), .sck(sck), .cs_n(cs_n),
    .si(si), .wp_n(wp_n), .so_out(so_out), .so_oe_n(so_oe_n), .op_start(op_start),
    .op_code(op_code), .op_suspend(op_suspend), .sw_reset_req(sw_reset_req),
    .op_done(op_done), .status_byte(status_byte), .block_guard(block_guard),
    .lane2_data_mode(lane2_data_mode), .lane3_data_mode(lane3_data_mode));

  fsw_host_model u_fsw_host_model (.clk(clk), .sck(sck), .cs_n(cs_n), .si(si),
    .so_out(so_out), .so_oe_n(so_oe_n), .rd_byte(rd_byte), .oe_seen(oe_seen));

  always #25 clk = ~clk;

  always @(posedge clk) begin
    if (op_start === 1'b1) starts++;
    if (op_suspend === 1'b1) susp++;
    if (sw_reset_req === 1'b1) resets++;
  end

  // ==========================================================
  // Helpers
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic op(input logic [7:0] c, input logic [7:0] dat);
    if (c == 8'h01) u_fsw_host_model.frame({c, dat, 8'h00}, 2);
    else u_fsw_host_model.frame({c, 16'h0000}, 1);
    repeat (6) @(posedge clk);
  endtask : op

  task automatic done_pulse;
    op_done <= 1'b1;
    @(posedge clk);
    op_done <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : done_pulse

  task automatic finish_test;
    $display("errors=%0d checks=%0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test

  initial begin
    repeat (80000) @(posedge clk);
    error_cnt++;
    finish_test();
  end

  // ==========================================================
  // Main sequence
  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    wp_n = 1'b1;
    op_done = 1'b0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    chk(status_byte, 8'h00);
    for (int p = 0; p < 2; p++) begin
      foreach (ROWS[i]) begin
        n0 = starts;
        if (p == 1) op(8'h06, 8'h00);
        op(ROWS[i][7:0], 8'h00);
        chk(8'(starts - n0), {7'h0, p[0] | ~ROWS[i][8]});
        if (starts != n0) begin
          chk(op_code, ROWS[i][7:0]);
          chk(status_byte[0], 8'h01);
          done_pulse();
          chk(status_byte, {6'h0, p[0] & ~ROWS[i][8], 1'b0});
        end
      end
    end
    op(8'h04, 8'h00);
    chk(status_byte, 8'h00);
    op(8'h06, 8'h00);
    u_fsw_host_model.frame({8'h05, 16'h0000}, 3);
    chk(rd_byte, 8'h02);
    chk(oe_seen, 8'h01);
    n0 = starts;
    op(8'h01, 8'hfc);
    chk(8'(starts - n0), 8'h01);
    chk(status_byte, 8'hff);
    chk(block_guard, 8'h0f);
    chk({lane3_data_mode, lane2_data_mode}, 8'h03);
    op(8'h75, 8'h00);
    chk(susp, 8'h00);
    u_fsw_host_model.frame({8'h05, 16'h0000}, 2);
    chk(rd_byte, 8'hff);
    done_pulse();
    chk(status_byte, 8'hfc);
    op(8'h06, 8'h00);
    op(8'hc7, 8'h00);
    chk(8'(starts - n0), 8'h01);
    chk(status_byte, 8'hfe);
    wp_n <= 1'b0;
    op(8'h06, 8'h00);
    op(8'h01, 8'h00);
    chk(8'(starts - n0), 8'h01);
    chk(status_byte, 8'hfe);
    wp_n <= 1'b1;
    op(8'h01, 8'h00);
    chk(8'(starts - n0), 8'h02);
    done_pulse();
    chk(status_byte, 8'h00);
    op(8'h06, 8'h00);
    op(8'h02, 8'h00);
    op(8'h20, 8'h00);
    chk(8'(starts - n0), 8'h03);
    op(8'h75, 8'h00);
    chk(susp, 8'h01);
    op(8'h99, 8'h00);
    chk(resets, 8'h01);
    done_pulse();
    chk(status_byte, 8'h00);
    op(8'h06, 8'h00);
    rstn <= 1'b0;
    repeat (8) @(posedge clk);
    chk(status_byte, 8'h00);
    chk(so_oe_n, 8'h01);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    chk(status_byte, 8'h00);
    op(8'h06, 8'h00);
    chk(status_byte, 8'h02);
    finish_test();
  end
endmodule : tb
`default_nettype wire
